// ### rtl/counter_unit_map.svh
`ifndef COUNTER_UNIT_MAP_SVH
`define COUNTER_UNIT_MAP_SVH

// register offsets on the plain register port
`define CNT_OFF_CONTROL      4'h0
`define CNT_OFF_LOW         4'h1
`define CNT_OFF_HIGH        4'h2
`define CNT_OFF_STATUS      4'h3

// control field positions
`define CTL_RUN_BIT         0
`define CTL_SRC_BIT         1
`define CTL_SYNC_BIT        2
`define CTL_PRE_LO          4
`define CTL_PRE_HI          5
`define CTL_WIDE_BIT        7
`define CTL_WRITE_MASK      8'hB7
`define CTL_RESET           8'h00

// internal count clock is the core clock divided by four
`define INT_DIV             2'h3

`endif

// ### rtl/counter_unit_pkg.sv
package counter_unit_pkg;

    // one register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage : counter_unit_pkg

// ### rtl/counter_unit.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
// Operation
// - the count is one 16-bit value held as a high byte register and a low byte register.
// - software can read and write both the high byte and the low byte of the count.
// - a rollover from all ones to zero raises an overflow request.
// - software selects the count clock between an internal source and an external input.
// - control bit 0 runs the counter when set and holds the value when clear.
// - control bit 7 set gives one 16-bit access through a buffered high byte, clear gives two byte accesses.
`include "counter_unit_map.svh"

module counter_unit
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_resetn,
    input  wire counter_unit_pkg::reg_req_s i_req,
    input  wire logic                      i_external_count_pin,
    input  wire logic                      i_overflow_clear,
    output logic [7:0]                     o_rdata,
    output logic                           o_overflow
);

    ////////////////////////////////////////////////////////////////////////
    // state registers: one flop group per register, each with a _next value
    logic [7:0]  timer_control_reg;
    logic [7:0]  count_low_byte_reg;
    logic [7:0]  count_high_byte_reg;
    logic [7:0]  high_buffer_reg;
    logic [7:0]  rdata_reg;
    logic        overflow_reg;
    logic [1:0]  div_reg;
    logic [2:0]  pin_sync_reg;
    logic        pin_prev_reg;
    logic        pin_raw_prev_reg;
    logic [2:0]  pre_cnt_reg;

    // next values, all formed by continuous assignments below
    logic [7:0]  timer_control_next;
    logic [7:0]  count_low_byte_next;
    logic [7:0]  count_high_byte_next;
    logic [7:0]  high_buffer_next;
    logic [7:0]  rdata_next;
    logic        overflow_next;
    logic [1:0]  div_next;
    logic [2:0]  pin_sync_next;
    logic        pin_prev_next;
    logic        pin_raw_prev_next;
    logic [2:0]  pre_cnt_next;

    ////////////////////////////////////////////////////////////////////////
    // address decode; unmapped offsets neither store nor answer
    wire wr_ctl  = i_req.wr && (i_req.addr == `CNT_OFF_CONTROL);
    wire wr_low  = i_req.wr && (i_req.addr == `CNT_OFF_LOW);
    wire wr_high = i_req.wr && (i_req.addr == `CNT_OFF_HIGH);
    wire rd_low  = i_req.rd && (i_req.addr == `CNT_OFF_LOW);

    // control fields
    wire       run     = timer_control_reg[`CTL_RUN_BIT];
    wire       src_ext = timer_control_reg[`CTL_SRC_BIT];
    wire       no_sync = timer_control_reg[`CTL_SYNC_BIT];
    wire       wide    = timer_control_reg[`CTL_WIDE_BIT];
    wire [1:0] pre_sel = timer_control_reg[`CTL_PRE_HI:`CTL_PRE_LO];

    ////////////////////////////////////////////////////////////////////////
    // count clock sources
    // synced edge: a change counts once second and third stages agree, so a
    // runt pulse shorter than one core cycle is filtered with no latency added over the bypass edge
    wire pin_agree = (pin_sync_reg[1] == pin_sync_reg[2]);
    wire sync_edge = pin_sync_reg[1] && pin_sync_reg[2] && !pin_prev_reg;
    // bypass skips the agreement filter only; the pin never reaches logic raw
    wire raw_edge  = pin_sync_reg[2] && !pin_raw_prev_reg;
    wire ext_tick  = no_sync ? raw_edge : sync_edge;

    // internal source: core clock over four, free running divider
    wire int_tick  = (div_reg == `INT_DIV);
    wire src_tick  = src_ext ? ext_tick : int_tick;

    // prescaler 1:1, 1:2, 1:4, 1:8; for 1:8 the shift wraps to zero and the
    // subtraction wraps to seven, which is the wanted top
    wire [2:0] pre_top  = (3'h1 << pre_sel) - 3'h1;
    wire       pre_wrap = (pre_cnt_reg == pre_top);
    wire       tick     = run && src_tick && pre_wrap;

    ////////////////////////////////////////////////////////////////////////
    // count value
    wire [15:0] count_now = {count_high_byte_reg, count_low_byte_reg};
    wire [15:0] count_inc = count_now + 16'h0001;
    wire        rollover  = tick && (count_now == 16'hFFFF);

    // byte access steering
    wire load_high_direct = wr_high && !wide;
    wire load_high_buffer = wr_high && wide;
    wire load_from_buffer = wr_low && wide;
    wire latch_buffer     = rd_low && wide;

    ////////////////////////////////////////////////////////////////////////
    // read mux; the high byte in wide mode answers from the buffer snapshot
    wire [7:0] rd_mux =
        (i_req.addr == `CNT_OFF_CONTROL) ? (timer_control_reg & `CTL_WRITE_MASK) :
        (i_req.addr == `CNT_OFF_LOW)     ? count_low_byte_reg :
        (i_req.addr == `CNT_OFF_HIGH)    ? (wide ? high_buffer_reg : count_high_byte_reg) :
        (i_req.addr == `CNT_OFF_STATUS)  ? {7'h00, overflow_reg} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // next values
    // control: reserved bits 6 and 3 never store a one
    assign timer_control_next = wr_ctl ? (i_req.wdata & `CTL_WRITE_MASK) : timer_control_reg;

    // low byte: a software write wins and the tick of that cycle is lost
    assign count_low_byte_next =
        wr_low ? i_req.wdata :
        tick   ? count_inc[7:0] :
                 count_low_byte_reg;

    // high byte: direct write, buffer copy on a wide low write, or the carry
    assign count_high_byte_next =
        load_high_direct   ? i_req.wdata :
        load_from_buffer   ? high_buffer_reg :
        (tick && !wr_low)  ? count_inc[15:8] :
                             count_high_byte_reg;

    // buffer: takes a wide high write, or snapshots high on a wide low read
    assign high_buffer_next =
        load_high_buffer ? i_req.wdata :
        latch_buffer     ? count_high_byte_reg :
                           high_buffer_reg;

    // read data stands for one cycle after the strobe, zero otherwise
    assign rdata_next = i_req.rd ? rd_mux : 8'h00;

    // overflow: set wins over clear in the same cycle
    assign overflow_next = rollover         ? 1'b1 :
                           i_overflow_clear ? 1'b0 :
                                              overflow_reg;

    // clock source state
    assign div_next          = div_reg + 2'h1;
    assign pin_sync_next     = {pin_sync_reg[1:0], i_external_count_pin};
    assign pin_prev_next     = pin_agree ? pin_sync_reg[2] : pin_prev_reg;
    assign pin_raw_prev_next = pin_sync_reg[2];

    // prescaler restarts on any control write so a new ratio starts clean
    assign pre_cnt_next =
        wr_ctl              ? 3'h0 :
        (run && src_tick)   ? (pre_wrap ? 3'h0 : pre_cnt_reg + 3'h1) :
                              pre_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            timer_control_reg <= `CTL_RESET;
        end
        else
        begin
            timer_control_reg <= timer_control_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low count byte
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count_low_byte_reg <= 8'h00;
        end
        else
        begin
            count_low_byte_reg <= count_low_byte_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // high count byte
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count_high_byte_reg <= 8'h00;
        end
        else
        begin
            count_high_byte_reg <= count_high_byte_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // high byte buffer for wide access
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            high_buffer_reg <= 8'h00;
        end
        else
        begin
            high_buffer_reg <= high_buffer_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flag
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            overflow_reg <= 1'b0;
        end
        else
        begin
            overflow_reg <= overflow_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal divider
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            div_reg <= 2'h0;
        end
        else
        begin
            div_reg <= div_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser, three stages
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_sync_reg <= 3'h0;
        end
        else
        begin
            pin_sync_reg <= pin_sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // last agreed pin level; reset low matches the idle pin, no false edge
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_prev_reg <= 1'b0;
        end
        else
        begin
            pin_prev_reg <= pin_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // previous third stage for the bypass edge
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_raw_prev_reg <= 1'b0;
        end
        else
        begin
            pin_raw_prev_reg <= pin_raw_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler counter
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pre_cnt_reg <= 3'h0;
        end
        else
        begin
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign o_rdata    = rdata_reg;
    assign o_overflow = overflow_reg;

endmodule : counter_unit

// ### bench/counter_unit_props.sv
`timescale 1ns/1ns
module counter_unit_props
(
    input logic                       i_sys_clk,
    input logic                       i_resetn,
    input counter_unit_pkg::reg_req_s i_req,
    input logic                       i_external_count_pin,
    input logic                       i_overflow_clear,
    input logic [7:0]                 o_rdata,
    input logic                       o_overflow
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    a_rdata_slot: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00) else $error("stray data");
    a_status_bit: assert property ($past(i_req.rd && i_req.addr == 4'h3) |-> o_rdata[0] == $past(o_overflow))
        else $error("bad status");
    a_flag_sticky: assert property (o_overflow && !i_overflow_clear |=> o_overflow) else $error("flag lost");
    a_flag_drop: assert property ($fell(o_overflow) |-> $past(i_overflow_clear)) else $error("flag fell");
    a_ctl_reserved: assert property ($past(i_req.rd && i_req.addr == 4'h0) |-> !o_rdata[6] && !o_rdata[3])
        else $error("reserved bit set");
    a_unmapped_zero: assert property ($past(i_req.rd && i_req.addr > 4'h3) |-> o_rdata == 8'h00)
        else $error("unmapped data");
    c_rollover: cover property ($rose(o_overflow));
    c_clear: cover property (o_overflow && i_overflow_clear);
    c_read: cover property (i_req.rd);
endmodule : counter_unit_props
bind counter_unit counter_unit_props u_props (.*);

// ### bench/count_source.sv
`timescale 1ns/1ns
module count_source
(
    input  logic i_sys_clk,
    input  logic i_go,
    output logic o_pin
);
    logic [2:0] phase_reg;
    // four cycles high, four low: slower than clk/2
    always_ff @(posedge i_sys_clk) phase_reg <= i_go ? phase_reg + 3'h1 : 3'h0;
    assign o_pin = phase_reg[2];
endmodule : count_source

// ### bench/counter_unit_tb.sv
`timescale 1ns/1ns
module counter_unit_tb;
    logic                       i_sys_clk = 1'b0, i_resetn = 1'b0, go = 1'b0, i_overflow_clear = 1'b0;
    logic                       i_external_count_pin, o_overflow;
    logic [7:0]                 o_rdata;
    counter_unit_pkg::reg_req_s i_req = '0;
    int                         errors = 0, checked = 0, n;
    always #10 i_sys_clk = ~i_sys_clk;
    counter_unit DUT
    (
        .i_sys_clk            (i_sys_clk),
        .i_resetn             (i_resetn),
        .i_req                (i_req),
        .i_external_count_pin (i_external_count_pin),
        .i_overflow_clear     (i_overflow_clear),
        .o_rdata              (o_rdata),
        .o_overflow           (o_overflow)
    );
    count_source src (.i_sys_clk, .i_go(go), .o_pin(i_external_count_pin));
    ////////////////////////
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        errors += int'(got !== exp);
        if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
    endtask : cmp
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) i_req <= '{a, d, w, !w};
        @(posedge i_sys_clk) i_req <= '0;
        #1 if (!w) cmp(o_rdata, d);
    endtask : bus
    // five pin rising edges, then the pin settles low
    task pin_burst;
        @(posedge i_sys_clk) go <= 1'b1;
        repeat (40) @(posedge i_sys_clk);
        go <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
    endtask : pin_burst
    task wrap_up;
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task t_regs;
        bus(0, 4'h0, 8'h00);
        bus(1, 4'h0, 8'hff);
        bus(0, 4'h0, 8'hb7);
        bus(1, 4'h2, 8'h12);
        bus(1, 4'h1, 8'h34);
        bus(0, 4'h1, 8'h34);
        bus(0, 4'h2, 8'h12);
        bus(1, 4'h5, 8'h55);
        bus(0, 4'h5, 8'h00);
    endtask : t_regs
    // synced pin edges first, then internal ticks from fff0 up to the rollover, then the flag clear
    task t_count;
        bus(1, 4'h0, 8'h03);
        pin_burst;
        bus(0, 4'h1, 8'h39);
        bus(1, 4'h2, 8'hff);
        bus(1, 4'h1, 8'hf0);
        bus(1, 4'h0, 8'h01);
        for (n = 0; n < 100 && o_overflow !== 1'b1; n++)
        begin
            @(posedge i_sys_clk);
            #1;
        end
        cmp(8'(n >= 61 && n <= 64), 8'h01);
        bus(0, 4'h3, 8'h01);
        @(posedge i_sys_clk) i_overflow_clear <= 1'b1;
        @(posedge i_sys_clk) i_overflow_clear <= 1'b0;
        bus(0, 4'h3, 8'h00);
    endtask : t_count
    // bypassed pin edges through a 1:2 prescaler, then a stopped counter
    task t_prescale;
        bus(1, 4'h0, 8'h00);
        bus(1, 4'h1, 8'h00);
        bus(1, 4'h2, 8'h00);
        bus(1, 4'h0, 8'h17);
        pin_burst;
        bus(0, 4'h1, 8'h02);
        bus(1, 4'h0, 8'h06);
        pin_burst;
        bus(0, 4'h1, 8'h02);
        bus(0, 4'h2, 8'h00);
    endtask : t_prescale
    // reset for two cycles first
    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        t_regs;
        t_count;
        t_prescale;
        wrap_up;
    end
endmodule : counter_unit_tb
